// ==== verilog/dpsc_consts.svh ====
// Purpose: Constants for the power-state control pair
// Assumes: Cycle counts at a 200 MHz clock
// Notes: Types live in dpsc_pkg
`ifndef DPSC_CONSTS_SVH
`define DPSC_CONSTS_SVH
`define DPSC_CLK_MHZ 200
`define DPSC_NBANKS 8
`define DPSC_BURST_CYC 4
`define DPSC_XS_CYC 10'h060
`define DPSC_XSDLL_CYC 10'h200
`define DPSC_WR_AFTER_SRX_CYC 10'h200
`define DPSC_MRD_CYC 10'h004
`define DPSC_MOD_CYC 10'h00C
`define DPSC_CKE_MIN_CYC 10'h003
`define DPSC_BUSY_CYC 10'h010
`endif

// ==== verilog/dpsc_pkg.sv ====
// Purpose: Types for the power-state control pair
// Assumes: Command coding cs, ras, cas, we
// Notes: None
package dpsc_pkg;
  typedef enum logic [3:0] {
    DPSC_C_IDLE, DPSC_C_MRS, DPSC_C_REF, DPSC_C_PRE, DPSC_C_ACT,
    DPSC_C_WR, DPSC_C_RD, DPSC_C_ZQ
  } dpsc_cmd_t;
  typedef enum logic [2:0] {
    DPSC_ST_ACTIVE, DPSC_ST_APD, DPSC_ST_PPD, DPSC_ST_SREF
  } dpsc_state_t;
endpackage

// ==== verilog/dpsc_if.sv ====
// Purpose: Pins between controller and device
// Assumes: One clock
// Notes: None
`timescale 1ns/1ps
interface dpsc_if (input wire logic clk);
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic a10;
  logic [2:0] ba;
  logic on_die_termination;
  modport dev (input clk, cke, cs_n, ras_n, cas_n, we_n, a10, ba, on_die_termination);
  modport ctl (input clk, output cke, cs_n, ras_n, cas_n, we_n, a10, ba,
    on_die_termination);
endinterface

// ==== verilog/dpsc_device.sv ====
// Purpose: Device end power-state logic
// Assumes: Pins synchronous to the clock
// Notes: Self refresh exit taken on the enable level
`timescale 1ns/1ps
`include "dpsc_consts.svh"
module dpsc_device #(
  parameter int NBANKS = `DPSC_NBANKS,
  parameter int BURST_CYC = `DPSC_BURST_CYC
) (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  dpsc_if.dev PINS,
  output dpsc_pkg::dpsc_state_t STATE_O,
  output logic [NBANKS-1:0] BANK_OPEN_O,
  output logic IDLE_O,
  output logic ODT_ACTIVE_O,
  output logic REFRESHING_O
);
  import dpsc_pkg::*;
  initial begin
    if (NBANKS != 8 || BURST_CYC < 1 || BURST_CYC > 15)
      $error("dpsc_device: bad parameters");
  end
  // ****************************************
  // Command decode
  // ****************************************
  logic cke_prev_reg;
  dpsc_state_t state_reg;
  logic [NBANKS-1:0] open_reg;
  logic [3:0] burst_reg;
  logic [9:0] timer_reg;
  dpsc_cmd_t cmd;
  logic [3:0] pins;
  always_comb begin
    pins = {PINS.cs_n, PINS.ras_n, PINS.cas_n, PINS.we_n};
    if (pins[3] || pins == 4'h7) cmd = DPSC_C_IDLE;
    else if (pins == 4'h0) cmd = DPSC_C_MRS;
    else if (pins == 4'h1) cmd = DPSC_C_REF;
    else if (pins == 4'h2) cmd = DPSC_C_PRE;
    else if (pins == 4'h3) cmd = DPSC_C_ACT;
    else if (pins == 4'h4) cmd = DPSC_C_WR;
    else if (pins == 4'h5) cmd = DPSC_C_RD;
    else cmd = DPSC_C_ZQ;
  end
  wire logic low_now = !PINS.cke;
  wire logic fall = cke_prev_reg && low_now;
  wire logic run = state_reg == DPSC_ST_ACTIVE && !low_now && cke_prev_reg;
  // ****************************************
  // Power state
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) cke_prev_reg <= 1'b0;
    else if (CE_I) cke_prev_reg <= PINS.cke;
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) state_reg <= DPSC_ST_ACTIVE;
    else if (CE_I) begin
      case (state_reg)
        DPSC_ST_ACTIVE: begin
          if (fall && cmd == DPSC_C_REF && open_reg == '0 && burst_reg == '0)
            state_reg <= DPSC_ST_SREF;
          else if (fall && cmd == DPSC_C_IDLE) begin
            if (open_reg == '0) state_reg <= DPSC_ST_PPD;
            else state_reg <= DPSC_ST_APD;
          end
        end
        DPSC_ST_APD, DPSC_ST_PPD, DPSC_ST_SREF: begin
          if (!low_now) state_reg <= DPSC_ST_ACTIVE;
        end
        default: state_reg <= DPSC_ST_ACTIVE;
      endcase
    end
  end
  // ****************************************
  // Bank record and bursts
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) open_reg <= '0;
    else if (CE_I && run) begin
      if (cmd == DPSC_C_ACT) open_reg[PINS.ba] <= 1'b1;
      else if (cmd == DPSC_C_PRE && PINS.a10) open_reg <= '0;
      else if (cmd == DPSC_C_PRE) open_reg[PINS.ba] <= 1'b0;
      else if ((cmd == DPSC_C_WR || cmd == DPSC_C_RD) && PINS.a10)
        open_reg[PINS.ba] <= 1'b0;
    end
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) burst_reg <= 4'h0;
    else if (CE_I) begin
      if (run && (cmd == DPSC_C_WR || cmd == DPSC_C_RD))
        burst_reg <= 4'(BURST_CYC);
      else if (burst_reg != 4'h0) burst_reg <= burst_reg - 4'h1;
    end
  end
  // ****************************************
  // Pending timing
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) timer_reg <= 10'h000;
    else if (CE_I) begin
      if (state_reg == DPSC_ST_SREF && !low_now)
        timer_reg <= `DPSC_XSDLL_CYC;
      else if (run && cmd == DPSC_C_MRS) timer_reg <= `DPSC_MOD_CYC;
      else if (run && (cmd == DPSC_C_REF || cmd == DPSC_C_ZQ))
        timer_reg <= `DPSC_BUSY_CYC;
      else if (timer_reg != 10'h000) timer_reg <= timer_reg - 10'h001;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) IDLE_O <= 1'b0;
    else if (CE_I)
      IDLE_O <= open_reg == '0 && burst_reg == '0 && PINS.cke &&
        timer_reg == 10'h000 && state_reg == DPSC_ST_ACTIVE;
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) ODT_ACTIVE_O <= 1'b0;
    else if (CE_I)
      ODT_ACTIVE_O <= PINS.on_die_termination && state_reg != DPSC_ST_SREF;
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) REFRESHING_O <= 1'b0;
    else if (CE_I)
      REFRESHING_O <= state_reg == DPSC_ST_SREF ||
        (run && cmd == DPSC_C_REF);
  end
  assign STATE_O = state_reg;
  assign BANK_OPEN_O = open_reg;
endmodule // dpsc_device

// ==== verilog/dpsc_controller.sv ====
// Purpose: Controller end driving enable and commands
// Assumes: User requests held until accepted
// Notes: Refuses power requests while hold, mode, burst or xs_reg timers run
`timescale 1ns/1ps
`include "dpsc_consts.svh"
module dpsc_controller #(
  parameter int CKE_MIN = `DPSC_CKE_MIN_CYC
) (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  dpsc_if.ctl PINS,
  input wire dpsc_pkg::dpsc_cmd_t CMD_I,
  input wire logic [2:0] BA_I,
  input wire logic A10_I,
  input wire logic CMD_VALID_I,
  input wire logic PD_REQ_I,
  input wire logic SR_REQ_I,
  input wire logic WAKE_I,
  input wire logic ODT_I,
  output logic CMD_READY_O,
  output logic PD_O,
  output logic SR_O
);
  import dpsc_pkg::*;
  initial begin
    if (CKE_MIN < 2 || CKE_MIN > 1023) $error("dpsc_controller: CKE_MIN");
  end
  logic cke_reg;
  logic boot_reg;
  logic sr_reg;
  logic [9:0] hold_reg;
  logic [9:0] mode_reg;
  logic [9:0] xs_reg;
  logic [9:0] xsdll_reg;
  logic [9:0] wr_reg;
  logic [3:0] busy_reg;
  logic [3:0] pins_next;
  // ****************************************
  // Acceptance checks
  // ****************************************
  wire logic hold_ok = hold_reg == 10'h000;
  wire logic mode_ok = mode_reg == 10'h000;
  wire logic pd_go = cke_reg && hold_ok && mode_ok && PD_REQ_I &&
    busy_reg == 4'h0 && xs_reg == 10'h000;
  wire logic sr_go = cke_reg && hold_ok && mode_ok && SR_REQ_I &&
    !PD_REQ_I && busy_reg == 4'h0 && xs_reg == 10'h000;
  wire logic wake_go = !cke_reg && hold_ok && WAKE_I;
  wire logic cmd_ok = CMD_VALID_I && cke_reg && xs_reg == 10'h000 &&
    !pd_go && !sr_go &&
    !((CMD_I == DPSC_C_RD) && xsdll_reg != 10'h000) &&
    !((CMD_I == DPSC_C_WR) && wr_reg != 10'h000);
  assign CMD_READY_O = cmd_ok;
  // ****************************************
  // Enable and pins
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) boot_reg <= 1'b1;
    else if (CE_I) boot_reg <= 1'b0;
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) cke_reg <= 1'b0;
    else if (CE_I) begin
      if (pd_go || sr_go) cke_reg <= 1'b0;
      else if (wake_go || boot_reg) cke_reg <= 1'b1;
    end
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) sr_reg <= 1'b0;
    else if (CE_I) begin
      if (sr_go) sr_reg <= 1'b1;
      else if (wake_go) sr_reg <= 1'b0;
    end
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) hold_reg <= 10'h000;
    else if (CE_I) begin
      if (pd_go || sr_go || wake_go || boot_reg)
        hold_reg <= 10'(CKE_MIN - 1);
      else if (hold_reg != 10'h000) hold_reg <= hold_reg - 10'h001;
    end
  end
  always_comb begin
    pins_next = 4'h7;
    if (sr_go) pins_next = 4'h1;
    else if (cmd_ok) begin
      case (CMD_I)
        DPSC_C_MRS: pins_next = 4'h0;
        DPSC_C_REF: pins_next = 4'h1;
        DPSC_C_PRE: pins_next = 4'h2;
        DPSC_C_ACT: pins_next = 4'h3;
        DPSC_C_WR: pins_next = 4'h4;
        DPSC_C_RD: pins_next = 4'h5;
        DPSC_C_ZQ: pins_next = 4'h6;
        default: pins_next = 4'h7;
      endcase
    end
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      PINS.cs_n <= 1'b1;
      {PINS.ras_n, PINS.cas_n, PINS.we_n} <= 3'h7;
      PINS.ba <= 3'h0;
      PINS.a10 <= 1'b0;
    end else if (CE_I) begin
      PINS.cs_n <= pins_next[3];
      {PINS.ras_n, PINS.cas_n, PINS.we_n} <= pins_next[2:0];
      PINS.ba <= BA_I;
      PINS.a10 <= A10_I;
    end
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) PINS.on_die_termination <= 1'b0;
    else if (CE_I) PINS.on_die_termination <= ODT_I && cke_reg && xsdll_reg == 10'h000;
  end
  assign PINS.cke = cke_reg;
  // ****************************************
  // Timers
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) mode_reg <= 10'h000;
    else if (CE_I) begin
      if (cmd_ok && CMD_I == DPSC_C_MRS) mode_reg <= `DPSC_MOD_CYC;
      else if (mode_reg != 10'h000) mode_reg <= mode_reg - 10'h001;
    end
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) busy_reg <= 4'h0;
    else if (CE_I) begin
      if (cmd_ok && (CMD_I == DPSC_C_WR || CMD_I == DPSC_C_RD))
        busy_reg <= 4'(`DPSC_BURST_CYC + 1);
      else if (busy_reg != 4'h0) busy_reg <= busy_reg - 4'h1;
    end
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      xs_reg <= 10'h000;
      xsdll_reg <= 10'h000;
      wr_reg <= 10'h000;
    end else if (CE_I) begin
      if (wake_go && sr_reg) begin
        xs_reg <= `DPSC_XS_CYC;
        xsdll_reg <= `DPSC_XSDLL_CYC;
        wr_reg <= `DPSC_WR_AFTER_SRX_CYC;
      end else begin
        if (xs_reg != 10'h000) xs_reg <= xs_reg - 10'h001;
        if (xsdll_reg != 10'h000) xsdll_reg <= xsdll_reg - 10'h001;
        if (wr_reg != 10'h000) wr_reg <= wr_reg - 10'h001;
      end
    end
  end
  assign PD_O = !cke_reg && !sr_reg;
  assign SR_O = sr_reg;
endmodule // dpsc_controller

// ==== sim/dpsc_checker.sv ====
// Purpose: Pin protocol checks for the power-state pair
// Assumes: One clock domain, watches the joining interface
// Notes: Helper counters track exit, mode and burst delays
`timescale 1ns/1ps
module dpsc_checker (
  input wire logic clk,
  input wire logic RESETN_I,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic a10,
  input wire logic [2:0] ba,
  input wire logic on_die_termination
);
  // ************
  // Helper logic
  // ************
  wire [2:0] rcw = {ras_n, cas_n, we_n};
  wire nop_c = cs_n | (rcw == 3'h7);
  wire ref_c = !cs_n && (rcw == 3'h1);
  wire rd_c = !cs_n && (rcw == 3'h5);
  wire wr_c = !cs_n && (rcw == 3'h4);
  logic in_sr;
  logic [9:0] srx_cnt;
  logic [3:0] mcnt;
  logic [2:0] bcnt;
  logic [7:0] open_b;
  default clocking @(posedge clk); endclocking
  default disable iff (!RESETN_I);
  always_ff @(posedge clk) begin
    if (!RESETN_I) in_sr <= 1'b0;
    else if (!cke && $past(cke) && ref_c) in_sr <= 1'b1;
    else if (cke) in_sr <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (!RESETN_I) srx_cnt <= 10'h3FF;
    else if (in_sr && cke) srx_cnt <= 10'h000;
    else if (srx_cnt != 10'h3FF) srx_cnt <= srx_cnt + 10'h001;
  end
  always_ff @(posedge clk) begin
    if (!RESETN_I) mcnt <= 4'h0;
    else if (!cs_n && rcw == 3'h0) mcnt <= 4'hB;
    else if (mcnt != 4'h0) mcnt <= mcnt - 4'h1;
  end
  always_ff @(posedge clk) begin
    if (!RESETN_I) bcnt <= 3'h0;
    else if (rd_c || wr_c) bcnt <= 3'h3;
    else if (bcnt != 3'h0) bcnt <= bcnt - 3'h1;
  end
  always_ff @(posedge clk) begin
    if (!RESETN_I) open_b <= 8'h00;
    else if (!cs_n && rcw == 3'h3) open_b[ba] <= 1'b1;
    else if (!cs_n && rcw == 3'h2 && a10) open_b <= 8'h00;
    else if (!cs_n && rcw == 3'h2) open_b[ba] <= 1'b0;
    else if ((rd_c || wr_c) && a10) open_b[ba] <= 1'b0;
  end
  // **********
  // Assertions
  // **********
  sequence s_sre;
    $fell(cke) && ref_c;
  endsequence
  sequence s_srx;
    in_sr && cke;
  endsequence
  a_entry_cmd_idle: assert property ($fell(cke) |-> nop_c || ref_c)
    else $error("Enable fell with a non-idle command");
  a_pd_exit_idle: assert property ($rose(cke) && !in_sr |-> nop_c)
    else $error("Powerdown exit with a non-idle command");
  a_sr_exit_idle: assert property (s_srx |-> nop_c)
    else $error("Self refresh exit with a non-idle command");
  a_cke_hold: assert property ($changed(cke) |=> $stable(cke))
    else $error("Enable toggled before minimum pulse");
  a_xs_quiet: assert property (srx_cnt < 10'h05F |-> nop_c)
    else $error("Command inside self refresh exit delay");
  a_lock_read: assert property (srx_cnt < 10'h1FF |-> !rd_c && !on_die_termination)
    else $error("Read or termination before lock delay");
  a_lock_write: assert property (srx_cnt < 10'h1FF |-> !wr_c)
    else $error("Write too soon after self refresh exit");
  a_mode_delay: assert property (mcnt != 4'h0 |-> cke)
    else $error("Enable low inside mode delays");
  a_sre_idle: assert property (s_sre |->
    open_b == 8'h00 && bcnt == 3'h0)
    else $error("Self refresh entry while not idle");
  a_low_quiet: assert property (!cke && !$past(cke) |-> nop_c)
    else $error("Command issued while enable low");
endmodule // dpsc_checker

// ==== sim/tb_dram_power_state_control.sv ====
// Purpose: Bench for controller and device facing each other
// Assumes: Second device driven directly for ignore checks
// Notes: State changes compared against a queue of notes
`timescale 1ns/1ps
module tb_dram_power_state_control;
  import dpsc_pkg::*;
  // *****
  // Setup
  // *****
  logic clk, rst_n, a10, valid, pd_req, sr_req, wake, odt_i, ready, pd, sr;
  logic odt_act;
  logic odt2, idle2, ref2, ce2;
  logic [2:0] ba, b;
  logic [7:0] bank_open;
  dpsc_cmd_t cmd;
  dpsc_state_t st, st2, prev;
  dpsc_state_t exp_q[$];
  int bad_count, num_checks, cyc, k, t0;
  dpsc_if dpsc_if_inst (.clk(clk));
  dpsc_if dpsc_if_inst2 (.clk(clk));
  dpsc_controller dpsc_controller_inst (.CLOCK_I(clk), .RESETN_I(rst_n),
    .CE_I(1'b1), .PINS(dpsc_if_inst), .CMD_I(cmd), .BA_I(ba), .A10_I(a10),
    .CMD_VALID_I(valid), .PD_REQ_I(pd_req), .SR_REQ_I(sr_req),
    .WAKE_I(wake), .ODT_I(odt_i), .CMD_READY_O(ready), .PD_O(pd), .SR_O(sr));
  dpsc_device dpsc_device_inst (.CLOCK_I(clk), .RESETN_I(rst_n), .CE_I(1'b1),
    .PINS(dpsc_if_inst), .STATE_O(st), .BANK_OPEN_O(bank_open), .IDLE_O(),
    .ODT_ACTIVE_O(odt_act), .REFRESHING_O());
  dpsc_device dpsc_device_inst2 (.CLOCK_I(clk), .RESETN_I(rst_n),
    .CE_I(ce2), .PINS(dpsc_if_inst2), .STATE_O(st2), .BANK_OPEN_O(),
    .IDLE_O(idle2), .ODT_ACTIVE_O(odt2), .REFRESHING_O(ref2));
  dpsc_checker dpsc_checker_inst (.clk(clk), .RESETN_I(rst_n),
    .cke(dpsc_if_inst.cke), .cs_n(dpsc_if_inst.cs_n),
    .ras_n(dpsc_if_inst.ras_n), .cas_n(dpsc_if_inst.cas_n),
    .we_n(dpsc_if_inst.we_n), .a10(dpsc_if_inst.a10),
    .ba(dpsc_if_inst.ba), .on_die_termination(dpsc_if_inst.on_die_termination));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // *****
  // Tasks
  // *****
  task end_sim;
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task send(input dpsc_cmd_t c, input logic [2:0] bb, input logic a);
    int i;
    cmd = c;
    ba = bb;
    a10 = a;
    valid = 1'b1;
    i = 0;
    #1;
    while (ready !== 1'b1 && i < 900) begin
      step(1);
      #1;
      i++;
    end
    step(1);
    valid = 1'b0;
    step(1);
    if (i == 900) bad_count++;
  endtask
  task power(input int m);
    int i;
    pd_req = (m == 0);
    sr_req = (m == 1);
    wake = (m == 2);
    for (i = 0; i < 900; i++) begin
      if ((m == 2) != (pd | sr)) break;
      step(1);
    end
    pd_req = 1'b0;
    sr_req = 1'b0;
    wake = 1'b0;
    step(1);
    if (i == 900) bad_count++;
  endtask
  // Monitor and timeout
  always @(negedge clk) begin
    if (!rst_n) prev = st;
    else if (st !== prev) begin
      chk(st, (exp_q.size() == 0) ? 8'hFF : exp_q.pop_front());
      prev = st;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim;
    end
  end
  // ********
  // Stimulus
  // ********
  initial begin
    void'($urandom(32'hA9025742));
    {rst_n, a10, valid, pd_req, sr_req, wake, odt_i, ba} = 10'h000;
    cmd = DPSC_C_IDLE;
    ce2 = 1'b1;
    {dpsc_if_inst2.cke, dpsc_if_inst2.cs_n, dpsc_if_inst2.ras_n} = 3'h7;
    {dpsc_if_inst2.cas_n, dpsc_if_inst2.we_n, dpsc_if_inst2.on_die_termination} = 3'h6;
    {dpsc_if_inst2.a10, dpsc_if_inst2.ba} = 4'h0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    step(2);
    b = 3'($urandom);
    for (k = 0; k < 3; k++) begin
      if (k != 1) send(DPSC_C_ACT, b, 1'b0);
      if (k == 0) chk(bank_open, 8'h01 << b);
      if (k == 2) send(DPSC_C_WR, b, 1'b0);
      if (k != 0) send(DPSC_C_PRE, b, 1'b1);
      exp_q.push_back(k == 0 ? DPSC_ST_APD : DPSC_ST_PPD);
      power(0);
      chk({pd, sr}, 8'h02);
      exp_q.push_back(DPSC_ST_ACTIVE);
      power(2);
    end
    send(DPSC_C_MRS, 3'h0, 1'b0);
    odt_i = 1'b1;
    exp_q.push_back(DPSC_ST_SREF);
    power(1);
    chk({pd, sr}, 8'h01);
    step(10);
    chk(odt_act, 1'b0);
    exp_q.push_back(DPSC_ST_ACTIVE);
    power(2);
    t0 = cyc;
    send(DPSC_C_ACT, 3'h0, 1'b0);
    send(DPSC_C_WR, 3'h0, 1'b0);
    chk(cyc - t0 >= 512, 1'b1);
    send(DPSC_C_RD, 3'h0, 1'b0);
    chk(idle2, 1'b1);
    dpsc_if_inst2.on_die_termination = 1'b1;
    step(2);
    chk(odt2, 1'b1);
    {dpsc_if_inst2.cke, dpsc_if_inst2.cs_n, dpsc_if_inst2.ras_n,
      dpsc_if_inst2.cas_n, dpsc_if_inst2.we_n} = 5'h01;
    step(3);
    chk(st2, DPSC_ST_SREF);
    chk(odt2, 1'b0);
    chk(ref2, 1'b1);
    {dpsc_if_inst2.cke, dpsc_if_inst2.cs_n} = 2'h3;
    step(3);
    chk(st2, DPSC_ST_ACTIVE);
    chk(idle2, 1'b0);
    dpsc_if_inst2.cke = 1'b0;
    step(3);
    chk(st2, DPSC_ST_PPD);
    chk(ref2, 1'b0);
    repeat (20) begin
      {dpsc_if_inst2.cs_n, dpsc_if_inst2.ras_n, dpsc_if_inst2.cas_n,
        dpsc_if_inst2.we_n, dpsc_if_inst2.a10} = 5'($urandom);
      step(1);
      chk(st2, DPSC_ST_PPD);
    end
    ce2 = 1'b0;
    dpsc_if_inst2.cke = 1'b1;
    step(3);
    chk(st2, DPSC_ST_PPD);
    ce2 = 1'b1;
    step(2);
    chk(st2, DPSC_ST_ACTIVE);
    step(4);
    chk(exp_q.size(), 8'h00);
    end_sim;
  end
endmodule // tb_dram_power_state_control
